// File: src/sar_ctrl_defs.vh
`ifndef SAR_CTRL_DEFS_VH
`define SAR_CTRL_DEFS_VH

// register offsets on the plain port
`define OFF_CONTROL     3'h0
`define OFF_CONFIG      3'h1
`define OFF_MUX         3'h2
`define OFF_RESULT_HI   3'h3
`define OFF_RESULT_LO   3'h4
`define OFF_BURST       3'h5

// converter_control_reg fields
`define CTL_DONE        7
`define CTL_BUSY        6
`define CTL_TRACK_DLY   5
`define CTL_SRC_HI      3
`define CTL_SRC_LO      0
`define CTL_RESET       8'h00

// converter_config_reg fields
`define CFG_SCALE_HI    7
`define CFG_SCALE_LO    3
`define CFG_BURST       2
`define CFG_RES_HI      1
`define CFG_RES_LO      0
`define CFG_RESET       8'hF8

// resolution codes
`define RES_10          2'h0
`define RES_8           2'h1
`define RES_12          2'h2

// start source codes
`define SRC_SOFT        4'h0
`define SRC_TMR0        4'h1
`define SRC_TMR1        4'h2
`define SRC_TMR2        4'h3
`define SRC_TMR3        4'h4
`define SRC_EXT         4'h5

// mux codes
`define MUX_TEMP        5'h10
`define MUX_REG_OUT     5'h11
`define MUX_SUPPLY      5'h12
`define MUX_GROUND      5'h13

// tracking and bit-cycle counts in conversion clocks
`define TRACK_CLOCKS    3'h4
`define BITS_8          4'h8
`define BITS_10         4'hA

// repeat count codes
`define RPT_1           3'h0
`define RPT_4           3'h1
`define RPT_8           3'h2
`define RPT_16          3'h3
`define RPT_32          3'h4
`define RPT_64          3'h5

`endif

// File: src/sar_clock_divider.v
`timescale 1ns/1ps
`default_nettype none

module sar_clock_divider #(
  parameter SCALE_W = 5
) (
  input  wire               clk,
  input  wire               reset_n,
  input  wire               burst_mode_enable,
  input  wire               hfosc_tick,
  input  wire [SCALE_W-1:0] clock_scaling_field,
  output reg                conversion_clock
);

  reg  [SCALE_W-1:0] count_reg;
  wire               src_tick;

  // source is every system clock, or the oscillator tick in burst mode
  assign src_tick = burst_mode_enable ? hfosc_tick : 1'b1;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg        <= {SCALE_W{1'b0}};
      conversion_clock <= 1'b0;
    end else begin
      conversion_clock <= 1'b0;
      if (src_tick) begin
        // divide by field plus one
        if (count_reg >= clock_scaling_field) begin
          count_reg        <= {SCALE_W{1'b0}};
          conversion_clock <= 1'b1;
        end else begin
          count_reg <= count_reg + 1'b1;
        end
      end
    end
  end

endmodule // sar_clock_divider

`default_nettype wire

// File: src/sar_input_mux.v
`timescale 1ns/1ps
`default_nettype none

`include "sar_ctrl_defs.vh"

module sar_input_mux (
  input  wire [4:0]  input_channel_select,
  output reg  [15:0] port_select,
  output reg         temp_select,
  output reg         reg_out_select,
  output reg         supply_select,
  output reg         ground_select
);

  always @* begin
    port_select    = 16'h0000;
    temp_select    = 1'b0;
    reg_out_select = 1'b0;
    supply_select  = 1'b0;
    ground_select  = 1'b0;
    if (!input_channel_select[4]) begin
      port_select[input_channel_select[3:0]] = 1'b1;
    end else begin
      case (input_channel_select)
        `MUX_TEMP:    temp_select    = 1'b1;
        `MUX_REG_OUT: reg_out_select = 1'b1;
        `MUX_SUPPLY:  supply_select  = 1'b1;
        `MUX_GROUND:  ground_select  = 1'b1;
        default:      ;
      endcase
    end
  end

endmodule // sar_input_mux

`default_nettype wire

// File: src/sar_conversion_control.v
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

`include "sar_ctrl_defs.vh"

module sar_conversion_control #(
  parameter SCALE_W = 5,
  parameter DATA_W  = 10,
  parameter ACC_W   = 16
) (
  input  wire              clk,
  input  wire              reset_n,
  input  wire [2:0]        addr,
  input  wire [7:0]        wdata,
  input  wire              write_strobe,
  input  wire              read_strobe,
  output reg  [7:0]        rdata,
  input  wire [3:0]        timer_overflow,
  input  wire              external_convert_start,
  input  wire              hfosc_tick,
  input  wire              interrupt_enable,
  output wire              conversion_interrupt,
  output wire [15:0]       port_select,
  output wire              temp_select,
  output wire              reg_out_select,
  output wire              supply_select,
  output wire              ground_select,
  output wire              conversion_clock,
  output reg               core_power,
  output reg               core_track,
  output reg               core_convert,
  output reg  [1:0]        core_resolution,
  input  wire              core_bit_done,
  input  wire [DATA_W-1:0] core_result
);

  localparam ST_IDLE  = 3'h0;
  localparam ST_POWER = 3'h1;
  localparam ST_TRACK = 3'h2;
  localparam ST_PIN   = 3'h3;
  localparam ST_CONV  = 3'h4;
  localparam ST_NEXT  = 3'h5;

  reg  [7:0]         control_reg;
  reg  [7:0]         config_reg;
  reg  [4:0]         mux_reg;
  reg  [2:0]         repeat_reg;
  reg  [ACC_W-1:0]   result_reg;
  reg  [ACC_W-1:0]   acc_reg;
  reg  [2:0]         state_reg;
  reg  [2:0]         track_count_reg;
  reg  [3:0]         bit_count_reg;
  reg  [6:0]         sample_count_reg;
  reg                ext_prev_reg;
  reg                done_reg;
  reg                busy_reg;

  wire [3:0]         source;
  wire               delayed_tracking_enable;
  wire               burst_mode_enable;
  wire [1:0]         resolution;
  wire               ext_rise;
  reg                trigger;
  reg  [6:0]         repeat_total;
  wire [3:0]         bit_total;
  wire [DATA_W-1:0]  sample;
  wire [ACC_W-1:0]   acc_sum;
  wire               last_bit;
  wire               last_sample;
  wire               done_set;
  wire               write_ctl;

  assign source                  = control_reg[`CTL_SRC_HI:`CTL_SRC_LO];
  assign delayed_tracking_enable = control_reg[`CTL_TRACK_DLY];
  assign burst_mode_enable       = config_reg[`CFG_BURST];
  assign resolution              = config_reg[`CFG_RES_HI:`CFG_RES_LO];
  assign ext_rise  = external_convert_start & ~ext_prev_reg;
  assign write_ctl = write_strobe && (addr == `OFF_CONTROL);

  sar_clock_divider #(
    .SCALE_W (SCALE_W)
  ) u_div (
    .clk                 (clk),
    .reset_n             (reset_n),
    .burst_mode_enable   (burst_mode_enable),
    .hfosc_tick          (hfosc_tick),
    .clock_scaling_field (config_reg[`CFG_SCALE_HI:`CFG_SCALE_LO]),
    .conversion_clock    (conversion_clock)
  );

  sar_input_mux u_mux (
    .input_channel_select (mux_reg),
    .port_select          (port_select),
    .temp_select          (temp_select),
    .reg_out_select       (reg_out_select),
    .supply_select        (supply_select),
    .ground_select        (ground_select)
  );

  always @* begin
    case (source)
      `SRC_SOFT: trigger = write_ctl && wdata[`CTL_BUSY];
      `SRC_TMR0: trigger = timer_overflow[0];
      `SRC_TMR1: trigger = timer_overflow[1];
      `SRC_TMR2: trigger = timer_overflow[2];
      `SRC_TMR3: trigger = timer_overflow[3];
      `SRC_EXT:  trigger = ext_rise;
      default:   trigger = 1'b0;
    endcase
  end

  // repeat count only applies in burst; otherwise one sample
  always @* begin
    case (repeat_reg)
      `RPT_1:  repeat_total = 7'd1;
      `RPT_4:  repeat_total = 7'd4;
      `RPT_8:  repeat_total = 7'd8;
      `RPT_16: repeat_total = 7'd16;
      `RPT_32: repeat_total = 7'd32;
      `RPT_64: repeat_total = 7'd64;
      default: repeat_total = 7'd1;
    endcase
    if (!burst_mode_enable) begin
      repeat_total = 7'd1;
    end
  end

  assign bit_total = (resolution == `RES_8) ? `BITS_8 : `BITS_10;
  // 8-bit mode keeps the two low bits at zero
  assign sample = (resolution == `RES_8) ?
                  {core_result[DATA_W-1:2], 2'b00} : core_result;
  assign acc_sum = acc_reg + {{(ACC_W-DATA_W){1'b0}}, sample};
  assign last_bit    = (bit_count_reg == bit_total - 4'h1);
  assign last_sample = (sample_count_reg == repeat_total - 7'd1);
  assign done_set    = (state_reg == ST_CONV) && core_bit_done &&
                       last_bit && last_sample;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg        <= ST_IDLE;
      track_count_reg  <= 3'h0;
      bit_count_reg    <= 4'h0;
      sample_count_reg <= 7'h00;
      acc_reg          <= {ACC_W{1'b0}};
      result_reg       <= {ACC_W{1'b0}};
      busy_reg         <= 1'b0;
      ext_prev_reg     <= 1'b0;
    end else begin
      ext_prev_reg <= external_convert_start;
      case (state_reg)
        ST_IDLE: begin
          // triggers arriving while busy are not looked at
          if (trigger) begin
            busy_reg         <= 1'b1;
            sample_count_reg <= 7'h00;
            acc_reg          <= {ACC_W{1'b0}};
            track_count_reg  <= 3'h0;
            if (burst_mode_enable) begin
              state_reg <= ST_POWER;
            end else if (delayed_tracking_enable &&
                         source != `SRC_EXT) begin
              state_reg <= ST_TRACK;
            end else begin
              state_reg <= ST_CONV;
            end
          end else if (delayed_tracking_enable && source == `SRC_EXT &&
                       !external_convert_start) begin
            state_reg <= ST_PIN;
          end
        end
        ST_PIN: begin
          if (ext_rise) begin
            busy_reg         <= 1'b1;
            sample_count_reg <= 7'h00;
            acc_reg          <= {ACC_W{1'b0}};
            state_reg        <= burst_mode_enable ? ST_POWER : ST_CONV;
          end else if (!(delayed_tracking_enable && source == `SRC_EXT)) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_POWER: begin
          if (conversion_clock) begin
            state_reg <= delayed_tracking_enable ? ST_TRACK : ST_CONV;
          end
        end
        ST_TRACK: begin
          if (conversion_clock) begin
            if (track_count_reg == `TRACK_CLOCKS - 3'h1) begin
              track_count_reg <= 3'h0;
              state_reg       <= ST_CONV;
            end else begin
              track_count_reg <= track_count_reg + 3'h1;
            end
          end
        end
        ST_CONV: begin
          if (core_bit_done) begin
            if (last_bit) begin
              bit_count_reg <= 4'h0;
              acc_reg       <= acc_sum;
              if (last_sample) begin
                result_reg <= acc_sum;
                busy_reg   <= 1'b0;
                state_reg  <= ST_IDLE;
              end else begin
                sample_count_reg <= sample_count_reg + 7'h01;
                state_reg        <= ST_NEXT;
              end
            end else begin
              bit_count_reg <= bit_count_reg + 4'h1;
            end
          end
        end
        ST_NEXT: begin
          state_reg <= delayed_tracking_enable ? ST_TRACK : ST_CONV;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // core drive; the tracking switch stays closed while powered and not converting
  always @* begin
    core_power      = !burst_mode_enable || (state_reg != ST_IDLE);
    core_convert    = (state_reg == ST_CONV);
    core_track      = !core_convert && core_power;
    core_resolution = resolution;
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      control_reg <= `CTL_RESET;
      config_reg  <= `CFG_RESET;
      mux_reg     <= 5'h1F;
      repeat_reg  <= `RPT_1;
      done_reg    <= 1'b0;
    end else begin
      if (write_strobe) begin
        case (addr)
          `OFF_CONTROL: control_reg <= {2'b00, wdata[5:0]};
          `OFF_CONFIG:  config_reg  <= wdata;
          `OFF_MUX:     mux_reg     <= wdata[4:0];
          `OFF_BURST:   repeat_reg  <= wdata[2:0];
          default:      ;
        endcase
      end
      // hardware set wins over a software clear in the same cycle
      if (done_set) begin
        done_reg <= 1'b1;
      end else if (write_ctl && !wdata[`CTL_DONE]) begin
        done_reg <= 1'b0;
      end
    end
  end

  assign conversion_interrupt = done_reg && interrupt_enable;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 8'h00;
    end else if (read_strobe) begin
      case (addr)
        `OFF_CONTROL:   rdata <= {done_reg, busy_reg, control_reg[5:0]};
        `OFF_CONFIG:    rdata <= config_reg;
        `OFF_MUX:       rdata <= {3'b000, mux_reg};
        `OFF_RESULT_HI: rdata <= result_reg[15:8];
        `OFF_RESULT_LO: rdata <= (resolution == `RES_8 &&
                                  !burst_mode_enable) ?
                                 8'h00 : result_reg[7:0];
        `OFF_BURST:     rdata <= {5'b00000, repeat_reg};
        default:        rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule // sar_conversion_control

`default_nettype wire

// File: verif/sar_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none

`include "sar_ctrl_defs.vh"

module sar_ctrl_checker (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [2:0]  addr,
  input wire logic [7:0]  wdata,
  input wire logic        write_strobe,
  input wire logic        read_strobe,
  input wire logic [7:0]  rdata,
  input wire logic        interrupt_enable,
  input wire logic        conversion_interrupt,
  input wire logic [15:0] port_select,
  input wire logic        temp_select,
  input wire logic        reg_out_select,
  input wire logic        supply_select,
  input wire logic        ground_select,
  input wire logic        core_track,
  input wire logic        core_convert
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  irq_gate_a: assert property (
    conversion_interrupt |-> interrupt_enable)
    else $error("interrupt without enable");
  rdata_idle_a: assert property (!$past(read_strobe) |-> rdata == 8'h00)
    else $error("read data outside read slot");
  port_route_a: assert property (
    (write_strobe && addr == `OFF_MUX && !wdata[4])
    |=> port_select == (16'h0001 << $past(wdata[3:0])))
    else $error("port input not routed");
  internal_route_a: assert property (
    (write_strobe && addr == `OFF_MUX && wdata[4])
    |=> port_select == 16'h0000 &&
        {temp_select, reg_out_select, supply_select, ground_select} ==
        ($past(wdata[3:2]) == 2'h0 ? 4'h8 >> $past(wdata[1:0]) : 4'h0))
    else $error("internal source not routed");
  mux_onehot_a: assert property (
    $onehot0({port_select, temp_select, reg_out_select, supply_select,
              ground_select}))
    else $error("more than one input routed");
  unmapped_read_a: assert property (
    (read_strobe && addr > `OFF_BURST) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  track_hold_a: assert property (!(core_track && core_convert))
    else $error("tracking while converting");
  done_source_a: assert property (
    ($rose(conversion_interrupt) && $past(interrupt_enable))
    |-> $past(core_convert))
    else $error("done set without conversion");
  done_sticky_a: assert property (
    ($fell(conversion_interrupt) && interrupt_enable &&
     $past(interrupt_enable))
    |-> $past(write_strobe && addr == `OFF_CONTROL))
    else $error("done cleared without software write");
endmodule // sar_ctrl_checker

bind sar_conversion_control sar_ctrl_checker chk_u (
  .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
  .write_strobe(write_strobe), .read_strobe(read_strobe), .rdata(rdata),
  .interrupt_enable(interrupt_enable),
  .conversion_interrupt(conversion_interrupt), .port_select(port_select),
  .temp_select(temp_select), .reg_out_select(reg_out_select),
  .supply_select(supply_select), .ground_select(ground_select),
  .core_track(core_track), .core_convert(core_convert)
);

`default_nettype wire

// File: verif/sar_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module sar_core_model #(
  parameter logic [9:0] VALUE = 10'h2A5
) (
  input wire logic  clk,
  input wire logic  reset_n,
  input wire logic  conversion_clock,
  input wire logic  core_convert,
  output logic      core_bit_done,
  output logic [9:0] core_result,
  output var int    bits
);
  // one bit decided per conversion clock while converting
  assign core_bit_done = core_convert && conversion_clock;
  // outside a conversion the word is not valid, so show a wrong one
  assign core_result = core_convert ? VALUE : ~VALUE;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bits <= 0;
    end else if (core_bit_done) begin
      bits <= bits + 1;
    end
  end
endmodule // sar_core_model

`default_nettype wire

// File: verif/sar_conversion_control_bench.sv
`timescale 1ns/1ps
`default_nettype none

`include "sar_ctrl_defs.vh"

`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin \
  n_fail++; $display("MISMATCH %s exp %h got %h", what, exp, got); end end

module sar_conversion_control_bench;
  logic        clk, reset_n, write_strobe, read_strobe;
  logic        external_convert_start, hfosc_tick, interrupt_enable;
  logic [2:0]  addr;
  logic [7:0]  wdata, rdata, v;
  logic [3:0]  timer_overflow;
  logic [15:0] port_select;
  logic        temp_select, reg_out_select, supply_select, ground_select;
  logic        conversion_interrupt, conversion_clock, core_power;
  logic        core_track, core_convert, core_bit_done;
  logic [1:0]  core_resolution;
  logic [9:0]  core_result;
  int          bits, b0, n_fail, checks;

  sar_conversion_control dut_u (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .rdata(rdata),
    .timer_overflow(timer_overflow),
    .external_convert_start(external_convert_start),
    .hfosc_tick(hfosc_tick), .interrupt_enable(interrupt_enable),
    .conversion_interrupt(conversion_interrupt), .port_select(port_select),
    .temp_select(temp_select), .reg_out_select(reg_out_select),
    .supply_select(supply_select), .ground_select(ground_select),
    .conversion_clock(conversion_clock), .core_power(core_power),
    .core_track(core_track), .core_convert(core_convert),
    .core_resolution(core_resolution), .core_bit_done(core_bit_done),
    .core_result(core_result)
  );

  sar_core_model core_u (
    .clk(clk), .reset_n(reset_n), .conversion_clock(conversion_clock),
    .core_convert(core_convert), .core_bit_done(core_bit_done),
    .core_result(core_result), .bits(bits)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // burst clock source ticks every other system clock
  initial hfosc_tick = 1'b0;
  always @(posedge clk) hfosc_tick <= ~hfosc_tick;

  task automatic complete_run;
    $display("n_fail=%0d checks=%0d", n_fail, checks);
    if (n_fail == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    write_strobe <= 1'b1;
    @(posedge clk);
    write_strobe <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    read_strobe <= 1'b1;
    @(posedge clk);
    read_strobe <= 1'b0;
    #1 d = rdata;
  endtask

  // polls the control register; a poll that never sees the bit ends the run
  task automatic wait_flag(input int idx, input logic val);
    int i;
    for (i = 0; i < 400; i++) begin
      rd(`OFF_CONTROL, v);
      if (v[idx] === val) return;
    end
    n_fail++;
    $display("MISMATCH control bit %0d exp %b got %b", idx, val, v[idx]);
    complete_run;
  endtask

  task automatic res(input logic [15:0] e);
    rd(`OFF_RESULT_HI, v);
    `CHK("result high", e[15:8], v)
    rd(`OFF_RESULT_LO, v);
    `CHK("result low", e[7:0], v)
  endtask

  initial begin
    int c;
    int s;
    reset_n = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    write_strobe = 1'b0;
    read_strobe = 1'b0;
    timer_overflow = 4'h0;
    external_convert_start = 1'b0;
    interrupt_enable = 1'b0;
    n_fail = 0;
    checks = 0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    rd(`OFF_CONFIG, v);
    `CHK("config reset", `CFG_RESET, v)
    rd(`OFF_CONTROL, v);
    `CHK("control reset", `CTL_RESET, v)
    rd(`OFF_MUX, v);
    `CHK("mux reset", 8'h1F, v)
    rd(3'h6, v);
    `CHK("unmapped read", 8'h00, v)
    for (c = 0; c < 21; c++) begin
      wr(`OFF_MUX, c[7:0]);
      `CHK("port select", (c < 16) ? 16'h0001 << c : 16'h0000, port_select)
      `CHK("internal select", (c > 15 && c < 20) ? 4'h8 >> (c - 16) : 4'h0,
           {temp_select, reg_out_select, supply_select, ground_select})
    end
    // single 10-bit software conversion, interrupt on
    wr(`OFF_CONFIG, 8'h08);
    interrupt_enable <= 1'b1;
    b0 = bits;
    wr(`OFF_CONTROL, 8'h40);
    `CHK("no track delay", 1'b1, core_convert)
    rd(`OFF_CONTROL, v);
    `CHK("busy during", 1'b1, v[`CTL_BUSY])
    wait_flag(`CTL_DONE, 1'b1);
    `CHK("busy after", 1'b0, v[`CTL_BUSY])
    `CHK("interrupt", 1'b1, conversion_interrupt)
    `CHK("bit cycles", 10, bits - b0)
    res(16'h02A5);
    // 8-bit conversion started while done is still set, polled
    interrupt_enable <= 1'b0;
    wr(`OFF_CONFIG, 8'h09);
    b0 = bits;
    wr(`OFF_CONTROL, 8'hC0);
    rd(`OFF_CONTROL, v);
    `CHK("done kept", 2'b11, v[7:6])
    `CHK("interrupt masked", 1'b0, conversion_interrupt)
    wait_flag(`CTL_BUSY, 1'b0);
    `CHK("bit cycles", 8, bits - b0)
    rd(`OFF_RESULT_LO, v);
    `CHK("low byte", 8'h00, v)
    interrupt_enable <= 1'b1;
    wr(`OFF_CONTROL, 8'h00);
    `CHK("done cleared", 1'b0, conversion_interrupt)
    // every hardware start source
    wr(`OFF_CONFIG, 8'h08);
    for (s = 1; s < 6; s++) begin
      wr(`OFF_CONTROL, s[7:0]);
      b0 = bits;
      @(posedge clk);
      if (s < 5) timer_overflow <= 4'h1 << (s - 1);
      else external_convert_start <= 1'b1;
      @(posedge clk);
      timer_overflow <= 4'h0;
      external_convert_start <= 1'b0;
      wait_flag(`CTL_DONE, 1'b1);
      `CHK("hardware start", 10, bits - b0)
      wr(`OFF_CONTROL, s[7:0]);
    end
    // delayed tracking, software start: four clocks of tracking first
    wr(`OFF_CONTROL, 8'h20);
    b0 = bits;
    wr(`OFF_CONTROL, 8'h60);
    `CHK("delay tracks", 1'b1, core_track)
    `CHK("delay holds off", 1'b0, core_convert)
    wait_flag(`CTL_DONE, 1'b1);
    `CHK("delay bits", 10, bits - b0)
    // delayed tracking, pin start: tracks while low, converts on rise
    wr(`OFF_CONTROL, 8'h25);
    @(posedge clk);
    `CHK("pin low tracks", 1'b1, core_track)
    `CHK("pin low waits", 1'b0, core_convert)
    b0 = bits;
    external_convert_start <= 1'b1;
    wait_flag(`CTL_DONE, 1'b1);
    `CHK("pin bits", 10, bits - b0)
    // back to software source before the pin drops, so no pin wait starts
    wr(`OFF_CONTROL, 8'h00);
    external_convert_start <= 1'b0;
    // burst of four with a second start that must be dropped
    wr(`OFF_BURST, {5'h00, `RPT_4});
    wr(`OFF_CONFIG, 8'h0C);
    b0 = bits;
    wr(`OFF_CONTROL, 8'h40);
    wr(`OFF_CONTROL, 8'h40);
    wait_flag(`CTL_DONE, 1'b1);
    `CHK("burst bits", 40, bits - b0)
    res(16'h0A94);
    repeat (200) @(posedge clk);
    `CHK("late start ignored", 40, bits - b0)
    complete_run;
  end
endmodule // sar_conversion_control_bench

`default_nettype wire
